// ===== npmc_chan_acc.sv
// one photodiode channel accumulator with hidden buffer
module npmc_chan_acc
   import npmc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // control
   input  wire logic        clear_in,
   input  wire logic        enable_in,
   input  wire logic [15:0] sample_in,
   // buffered result
   output logic [15:0]      acc_out
);
   typedef struct packed {
      logic [15:0] acc;
   } npmc_acc_t;
   npmc_acc_t   s;
   npmc_acc_t   next_s;
   logic [16:0] sum;

   always_comb begin
      next_s = s;
      // saturate instead of wrapping when a single or double count meets the top
      sum    = {1'b0, s.acc} + 17'h00001 + {16'h0000, sample_in[15]};
      if (clear_in) begin
         next_s.acc = 16'h0000;
      end else if (enable_in) begin
         next_s.acc = sum[16] ? 16'hFFFF : sum[15:0];
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign acc_out = s.acc;
endmodule

// ===== npmc_host_model.sv
// host model driving the register port of the sensor control block
module npmc_host_model (
   // register port toward the device
   input  wire logic       clk_in,
   output logic [7:0]      addr_out,
   output logic [7:0]      wdata_out,
   output logic            wr_out,
   output logic            rd_out,
   input  wire logic [7:0] rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one-cycle write, released bus shows no stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      @(negedge clk_in);
      d = rdata_in;
   endtask
endmodule

// ===== npmc_pkg.sv
// package: register indices, control bit positions, reset values, timing counts
package npmc_pkg;
   // register indices of the byte-wide map
   localparam logic [7:0] NPMC_IDX_SENS_CTRL  = 8'h00;
   localparam logic [7:0] NPMC_IDX_TIME_HI    = 8'h01;
   localparam logic [7:0] NPMC_IDX_TIME_LO    = 8'h02;
   localparam logic [7:0] NPMC_IDX_DATA_FIRST = 8'h03;
   localparam logic [7:0] NPMC_IDX_DATA_LAST  = 8'h08;
   localparam logic [7:0] NPMC_IDX_LED_CTRL   = 8'h0E;
   localparam logic [7:0] NPMC_IDX_LED_CUR    = 8'h0F;
   localparam logic [7:0] NPMC_IDX_STATUS     = 8'h10;
   // sensor control byte fields
   localparam int NPMC_SC_HOLD_BIT    = 7;
   localparam int NPMC_SC_STBY_BIT    = 6;
   localparam int NPMC_SC_MANUAL_BIT  = 2;
   localparam int NPMC_SC_TSTEP_LSB   = 0;
   localparam logic [7:0] NPMC_SC_RESET = 8'hC0;
   // led control byte fields
   localparam int NPMC_LC_RST_BIT     = 7;
   localparam int NPMC_LC_STBY_BIT    = 6;
   localparam int NPMC_LC_STEADY_BIT  = 5;
   localparam int NPMC_LC_TENTH_BIT   = 4;
   localparam logic [7:0] NPMC_LC_RESET = 8'hC0;
   localparam logic [7:0] NPMC_CUR_RESET = 8'h00;
   // timing
   localparam int NPMC_CLK_MHZ         = 25;
   localparam int NPMC_TINT_BASE_US    = 32;
   localparam int NPMC_TINT_BASE_CYC   = NPMC_TINT_BASE_US * NPMC_CLK_MHZ;
   localparam int NPMC_CHANNELS        = 3;
   localparam int NPMC_LED_PERIOD_CYC  = 100;
   localparam logic [1:0] NPMC_CH_LAST = 2'h2;
   // measurement sequencer states
   typedef enum logic [2:0] {
      NPMC_ST_STBY = 3'h1,
      NPMC_ST_INTG = 3'h2,
      NPMC_ST_STORE = 3'h4
   } npmc_state_t;
endpackage

// ===== npmc_top.sv
// measurement and led driver control of the infrared photodiode sensor
module npmc_top
   import npmc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [7:0]       reg_rdata_out,
   // converter input
   input  wire logic [15:0] pd_sample_in,
   // status and led
   output logic             measuring_out,
   output logic             result_valid_out,
   output logic             led_drive_out,
   output logic [7:0]       led_current_out
);
   typedef struct packed {
      logic [7:0]  sens_ctrl;
      logic [7:0]  time_hi;
      logic [7:0]  time_lo;
      logic [7:0]  led_ctrl;
      logic [7:0]  led_cur;
      npmc_state_t st;
      logic [1:0]  ch;
      logic [23:0] tcnt;
      logic [15:0] res0;
      logic [15:0] res1;
      logic [15:0] res2;
      logic        res_valid;
      logic [7:0]  rdata;
      logic [6:0]  led_cnt;
      logic        led_drive;
      logic        measuring;
   } npmc_regs_t;

   npmc_regs_t s;
   npmc_regs_t next_s;

   logic        hold_fall;
   logic        halt_req;
   logic [23:0] ch_len;
   logic        ch_done;
   logic        acc_clear;
   logic [2:0]  acc_en;
   logic [15:0] acc_val [NPMC_CHANNELS];
   logic [7:0]  wr_sc;
   logic        hold_after;
   logic        stby_after;

   ////////////////////////////////////////////////////////////////////
   // hidden channel buffers
   genvar g;
   generate
      for (g = 0; g < NPMC_CHANNELS; g++) begin : gen_acc
         npmc_chan_acc u_acc (
            .clk_in    (clk_in),
            .rst_b_in  (rst_b_in),
            .clear_in  (acc_clear),
            .enable_in (acc_en[g]),
            .sample_in (pd_sample_in),
            .acc_out   (acc_val[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // control decode
   always_comb begin
      wr_sc      = reg_wdata_in;
      hold_after = s.sens_ctrl[NPMC_SC_HOLD_BIT];
      stby_after = s.sens_ctrl[NPMC_SC_STBY_BIT];
      if (reg_wr_in && reg_addr_in == NPMC_IDX_SENS_CTRL) begin
         hold_after = wr_sc[NPMC_SC_HOLD_BIT];
         stby_after = wr_sc[NPMC_SC_STBY_BIT];
      end
      hold_fall = s.sens_ctrl[NPMC_SC_HOLD_BIT] && !hold_after;
      halt_req  = reg_wr_in && (reg_addr_in == NPMC_IDX_SENS_CTRL)
                  && (wr_sc[NPMC_SC_HOLD_BIT] || wr_sc[NPMC_SC_STBY_BIT]);
      // per-channel length: manual uses the timing count, else 32 us times 2^step
      if (s.sens_ctrl[NPMC_SC_MANUAL_BIT]) begin
         ch_len = 24'(NPMC_TINT_BASE_CYC) * {8'h00, s.time_hi, s.time_lo};
      end else begin
         ch_len = 24'(NPMC_TINT_BASE_CYC) << s.sens_ctrl[NPMC_SC_TSTEP_LSB +: 2];
      end
      ch_done   = (s.st == NPMC_ST_INTG) && (s.tcnt >= ch_len - 24'h000001);
      // fresh buffers at each start and after each store
      acc_clear = (hold_fall && !stby_after) || (s.st == NPMC_ST_STORE);
      acc_en    = '0;
      if (s.st == NPMC_ST_INTG && !halt_req) begin
         acc_en[s.ch] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_s = s;
      // register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            NPMC_IDX_SENS_CTRL: next_s.sens_ctrl = reg_wdata_in;
            NPMC_IDX_TIME_HI:   next_s.time_hi   = reg_wdata_in;
            NPMC_IDX_TIME_LO:   next_s.time_lo   = reg_wdata_in;
            NPMC_IDX_LED_CTRL:  next_s.led_ctrl  = reg_wdata_in;
            NPMC_IDX_LED_CUR:   next_s.led_cur   = reg_wdata_in;
            default: ;
         endcase
      end
      // read data one cycle later
      next_s.rdata = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            NPMC_IDX_SENS_CTRL: next_s.rdata = s.sens_ctrl;
            NPMC_IDX_TIME_HI:   next_s.rdata = s.time_hi;
            NPMC_IDX_TIME_LO:   next_s.rdata = s.time_lo;
            8'h03:              next_s.rdata = s.res0[15:8];
            8'h04:              next_s.rdata = s.res0[7:0];
            8'h05:              next_s.rdata = s.res1[15:8];
            8'h06:              next_s.rdata = s.res1[7:0];
            8'h07:              next_s.rdata = s.res2[15:8];
            NPMC_IDX_DATA_LAST: next_s.rdata = s.res2[7:0];
            NPMC_IDX_LED_CTRL:  next_s.rdata = s.led_ctrl;
            NPMC_IDX_LED_CUR:   next_s.rdata = s.led_cur;
            NPMC_IDX_STATUS:    next_s.rdata = {5'h00, s.res_valid, s.measuring, s.led_drive};
            default:            next_s.rdata = 8'h00;
         endcase
      end
      // measurement sequencer
      case (s.st)
         NPMC_ST_STBY: begin
            next_s.tcnt = 24'h000000;
            next_s.ch   = 2'h0;
            if (hold_fall && !stby_after) begin
               next_s.st = NPMC_ST_INTG;
            end
         end
         NPMC_ST_INTG: begin
            next_s.tcnt = s.tcnt + 24'h000001;
            if (halt_req) begin
               next_s.st = NPMC_ST_STBY;
            end else if (ch_done) begin
               next_s.tcnt = 24'h000000;
               if (s.ch == NPMC_CH_LAST) begin
                  next_s.st = NPMC_ST_STORE;
               end else begin
                  next_s.ch = s.ch + 2'h1;
               end
            end
         end
         NPMC_ST_STORE: begin
            next_s.res0      = acc_val[0];
            next_s.res1      = acc_val[1];
            next_s.res2      = acc_val[2];
            next_s.res_valid = 1'b1;
            next_s.ch        = 2'h0;
            if (halt_req) begin
               next_s.st = NPMC_ST_STBY;
            end else if (s.sens_ctrl[NPMC_SC_MANUAL_BIT]) begin
               next_s.st = NPMC_ST_STBY;
               next_s.sens_ctrl[NPMC_SC_STBY_BIT] = 1'b1;
            end else begin
               next_s.st = NPMC_ST_INTG;
            end
         end
         default: next_s.st = NPMC_ST_STBY;
      endcase
      next_s.measuring = (next_s.st != NPMC_ST_STBY);
      // led driver: runs when out of standby and reset released
      if (s.led_ctrl[NPMC_LC_STBY_BIT] || s.led_ctrl[NPMC_LC_RST_BIT]) begin
         next_s.led_cnt   = 7'h00;
         next_s.led_drive = 1'b0;
      end else if (s.led_ctrl[NPMC_LC_STEADY_BIT]) begin
         next_s.led_drive = 1'b1;
      end else begin
         next_s.led_cnt   = (s.led_cnt == 7'(NPMC_LED_PERIOD_CYC - 1)) ? 7'h00 : s.led_cnt + 7'h01;
         next_s.led_drive = (s.led_cnt < 7'(NPMC_LED_PERIOD_CYC / 10));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register; results cleared only here by reset
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s           <= '0;
         s.sens_ctrl <= NPMC_SC_RESET;
         s.led_ctrl  <= NPMC_LC_RESET;
         s.led_cur   <= NPMC_CUR_RESET;
         s.st        <= NPMC_ST_STBY;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata_out    = s.rdata;
   assign measuring_out    = s.measuring;
   assign result_valid_out = s.res_valid;
   assign led_drive_out    = s.led_drive;
   assign led_current_out  = s.led_cur;
endmodule

// ===== npmc_top_props.sv
// port checker for the measurement and led control block
module npmc_top_props
   import npmc_pkg::*;
(
   // watched ports
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic [15:0] pd_sample_in,
   input wire logic        measuring_out,
   input wire logic        result_valid_out,
   input wire logic        led_drive_out,
   input wire logic [7:0]  led_current_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] run_cnt;
   wire         sc_wr = reg_wr_in && (reg_addr_in == NPMC_IDX_SENS_CTRL);
   // cycles spent measuring in the current run
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) run_cnt <= 16'h0000;
      else if (!measuring_out) run_cnt <= 16'h0000;
      else if (run_cnt != 16'hFFFF) run_cnt <= run_cnt + 16'h0001;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////////////////////////////////////////
   a_reset_quiet: assert property ($rose(rst_b_in) |-> !measuring_out && !led_drive_out)
      else $error("activity right after reset");
   a_read_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data outside a read cycle");
   a_start_on_release: assert property ($rose(measuring_out) |-> $past(sc_wr) && $past(reg_wdata_in[7:6]) == 2'h0)
      else $error("measurement started without hold release");
   a_halt_on_write: assert property (sc_wr && (reg_wdata_in[7] || reg_wdata_in[6]) |=> !measuring_out)
      else $error("run not halted by hold or standby");
   a_led_standby_off: assert property (reg_wr_in && reg_addr_in == NPMC_IDX_LED_CTRL && reg_wdata_in[6]
      |-> ##2 !led_drive_out)
      else $error("led drive kept in standby");
   a_led_cur_copy: assert property (reg_wr_in && reg_addr_in == NPMC_IDX_LED_CUR
      |=> led_current_out == $past(reg_wdata_in))
      else $error("led current not taken");
   a_result_sticky: assert property (result_valid_out |=> result_valid_out)
      else $error("stored result flag dropped without reset");
   a_store_after_full: assert property ($rose(result_valid_out) |-> run_cnt >= 16'h095E)
      else $error("results stored before full integration");
   a_single_ends_full: assert property ($fell(measuring_out) && !$past(sc_wr) |-> run_cnt >= 16'h095E)
      else $error("single run ended early");
   cover property ($fell(measuring_out));
   cover property ($rose(result_valid_out));
   cover property ($rose(led_drive_out));
endmodule
bind npmc_top npmc_top_props u_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .pd_sample_in(pd_sample_in), .measuring_out(measuring_out), .result_valid_out(result_valid_out),
   .led_drive_out(led_drive_out), .led_current_out(led_current_out));

// ===== testbench.sv
// self-checking bench for the measurement and led control block
module testbench
   import npmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, rst_b_in, wr, rd, meas, rvalid, drive;
   logic [7:0]  addr, wdata, rdata, cur;
   logic [15:0] sample;
   int          err_total, cmp_count, n;
   npmc_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pd_sample_in(sample), .measuring_out(meas),
      .result_valid_out(rvalid), .led_drive_out(drive), .led_current_out(cur));
   npmc_host_model host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
      .rdata_in(rdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk8(d, exp);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      rst_b_in = 1'b0;
      sample = 16'h0000;
      err_total = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(negedge clk_in);
      chk1(meas, 1'b0);
      chk1(drive, 1'b0);
      chk8(cur, 8'h00);
      rdc(NPMC_IDX_SENS_CTRL, 8'hC0);
      rdc(NPMC_IDX_LED_CTRL, 8'hC0);
      rdc(8'h20, 8'h00);
      rdc(NPMC_IDX_DATA_FIRST, 8'h00);
      // single shot run, one count per cycle
      host.wr(NPMC_IDX_SENS_CTRL, 8'h8D);
      host.wr(NPMC_IDX_TIME_HI, 8'h00);
      host.wr(NPMC_IDX_TIME_LO, 8'h01);
      host.wr(NPMC_IDX_SENS_CTRL, 8'h0D);
      @(negedge clk_in);
      chk1(meas, 1'b1);
      n = 0;
      while (meas === 1'b1 && n < 3000) begin
         @(negedge clk_in);
         n++;
      end
      chk1(n >= 32'h960 && n <= 32'h962, 1'b1);
      rdc(NPMC_IDX_SENS_CTRL, 8'h4D);
      chk1(rvalid, 1'b1);
      rdc(NPMC_IDX_STATUS, 8'h04);
      for (int i = 0; i < 6; i += 2) begin
         rdc(NPMC_IDX_DATA_FIRST + i[7:0], 8'h03);
         rdc(NPMC_IDX_DATA_FIRST + i[7:0] + 8'h01, 8'h20);
      end
      // periodic run, two counts per cycle
      @(posedge clk_in);
      sample <= 16'h8000;
      host.wr(NPMC_IDX_SENS_CTRL, 8'h80);
      host.wr(NPMC_IDX_SENS_CTRL, 8'h00);
      repeat (2500) @(posedge clk_in);
      rdc(NPMC_IDX_DATA_FIRST, 8'h06);
      rdc(NPMC_IDX_DATA_LAST, 8'h40);
      chk1(meas, 1'b1);
      // second periodic result must not carry the first one
      repeat (2400) @(posedge clk_in);
      rdc(NPMC_IDX_DATA_FIRST, 8'h06);
      rdc(NPMC_IDX_DATA_LAST, 8'h40);
      chk1(meas, 1'b1);
      host.wr(NPMC_IDX_SENS_CTRL, 8'hC0);
      @(negedge clk_in);
      chk1(meas, 1'b0);
      rdc(NPMC_IDX_DATA_LAST, 8'h40);
      host.wr(NPMC_IDX_SENS_CTRL, 8'h40);
      @(negedge clk_in);
      chk1(meas, 1'b0);
      // led driver held in reset, then steady drive
      host.wr(NPMC_IDX_LED_CTRL, 8'hA0);
      host.wr(NPMC_IDX_LED_CUR, 8'h60);
      @(negedge clk_in);
      chk8(cur, 8'h60);
      chk1(drive, 1'b0);
      host.wr(NPMC_IDX_LED_CTRL, 8'h20);
      repeat (20) @(negedge clk_in);
      chk1(drive, 1'b1);
      // pulse drive: ten of every hundred cycles
      host.wr(NPMC_IDX_LED_CTRL, 8'h00);
      @(negedge clk_in);
      n = 0;
      repeat (200) begin
         @(negedge clk_in);
         if (drive === 1'b1) begin
            n++;
         end
      end
      chk8(n[7:0], 8'h14);
      host.wr(NPMC_IDX_LED_CTRL, 8'hC0);
      repeat (2) @(negedge clk_in);
      chk1(drive, 1'b0);
      // second power-on reset: results and controls back to defaults
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(negedge clk_in);
      chk1(rvalid, 1'b0);
      chk8(cur, 8'h00);
      rdc(NPMC_IDX_DATA_LAST, 8'h00);
      rdc(NPMC_IDX_SENS_CTRL, 8'hC0);
      stop_test();
   end
endmodule
